// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin error_cnt++; \
	$display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end
module tb_top;
	// ---------------------------------------------------------------
	// Stimulus, observed outputs and bookkeeping.
	// ---------------------------------------------------------------
	logic        clk     = 1'b0;
	logic        reset_n = 1'b0;
	logic        cyc     = 1'b0;
	logic        stb     = 1'b0;
	logic        we      = 1'b0;
	logic        ecc     = 1'b0;
	logic        trg     = 1'b0;
	logic [7:0]  adr     = 8'h00;
	logic [3:0]  sel     = 4'h0;
	logic [31:0] wdat    = 32'h0;
	logic [31:0] rdo, rd;
	logic [7:0]  hv;
	logic        ack, err, tgl, pwm, mpl, opl, rerr;
	logic        tgl_q   = 1'b0;
	int          error_cnt = 0, check_count = 0, cycles = 0;
	int          m_cnt = 0, o_cnt = 0, t_cnt = 0, m0, t0, o0, p, n, h;
	int          ratio [7] = '{2, 4, 8, 32, 128, 512, 2048};

	tmr_timer8 dut_u (
		.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(ack),
		.wb_err_o(err), .ext_count_clock(ecc), .capture_trigger_input(trg),
		.match_toggle_out(tgl), .pwm_wave_out(pwm), .match_irq_pulse(mpl),
		.overflow_irq_pulse(opl)
	);

	// Free-running 50 MHz clock.
	initial begin
		forever #10 clk = ~clk;
	end

	// Event counters and the run ceiling, so a hung wait still ends the run.
	always @(posedge clk) begin
		cycles++;
		if (mpl === 1'b1) m_cnt++;
		if (opl === 1'b1) o_cnt++;
		if (tgl !== tgl_q) t_cnt++;
		tgl_q <= tgl;
		if (cycles == 60000) begin
			error_cnt++;
			conclude();
		end
	end

	// ---------------------------------------------------------------
	// Bus and pin tasks.
	// ---------------------------------------------------------------
	// One classic cycle; the request stays put until ack or err is sampled.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s);
		@(posedge clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		sel  <= s;
		// No local timeout; without ack or err only the run ceiling ends this wait.
		do begin
			@(posedge clk);
		end while (ack !== 1'b1 && err !== 1'b1);
		rd = rdo;
		rerr = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d}, 4'hf);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
		bus(1'b0, a, 32'h0, 4'hf);
		`CHK(nm, {24'h0, e}, rd)
	endtask

	// Cycles up to and including the next match or overflow pulse.
	task automatic wait_ev(input bit ov, output int q);
		q = 0;
		do begin
			@(posedge clk);
			q++;
		end while ((ov ? opl : mpl) !== 1'b1 && q < 10000);
	endtask

	// Slow external clock pulses, well inside what the edge detector sees.
	task automatic ext(input int k);
		repeat (k) begin
			@(posedge clk) ecc <= 1'b1;
			repeat (2) @(posedge clk);
			ecc <= 1'b0;
			repeat (2) @(posedge clk);
		end
		repeat (4) @(posedge clk);
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Test sequence.
	// ---------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		rchk(tmr_pkg::OFS_CONTROL, tmr_pkg::RST_CONTROL, "control reset");
		rchk(tmr_pkg::OFS_COUNT, tmr_pkg::RST_COUNT, "count reset");
		rchk(tmr_pkg::OFS_MATCH, tmr_pkg::RST_MATCH, "match reset");
		bus(1'b0, 8'hb5, 32'h0, 4'hf);
		`CHK("unmapped err", 1'b1, rerr)
		// Writes without lane 0, and writes to the count, must change nothing.
		bus(1'b1, tmr_pkg::OFS_MATCH, 32'h12, 4'he);
		rchk(tmr_pkg::OFS_MATCH, 8'hff, "lane0 write");
		wr(tmr_pkg::OFS_COUNT, 8'h55);
		rchk(tmr_pkg::OFS_COUNT, 8'h00, "count read only");
		// Counter mode at every ratio: match 1 gives two ticks per period.
		wr(tmr_pkg::OFS_MATCH, 8'h01);
		m0 = m_cnt; t0 = t_cnt; o0 = o_cnt;
		for (int i = 0; i < 7; i++) begin
			wr(tmr_pkg::OFS_CONTROL, 8'h80 | 8'(i << 1));
			wait_ev(1'b0, p);
			wait_ev(1'b0, p);
			`CHK("match period", 2 * ratio[i], p)
		end
		repeat (4) @(posedge clk);
		`CHK("toggle per match", m_cnt - m0, t_cnt - t0)
		`CHK("no overflow", o0, o_cnt)
		// PWM mode: a full period holds match plus one high ticks.
		wr(tmr_pkg::OFS_MATCH, 8'h40);
		wr(tmr_pkg::OFS_CONTROL, 8'h90);
		m0 = m_cnt;
		wait_ev(1'b1, p);
		n = 0;
		h = 0;
		do begin
			@(posedge clk);
			n++;
			h += int'(pwm);
		end while (opl !== 1'b1 && n < 10000);
		`CHK("pwm period", 512, n)
		`CHK("pwm high", 130, h)
		`CHK("pwm match", 1'b1, m_cnt > m0)
		// Disabled timer holds; the clear bit zeroes the count and drops itself.
		wr(tmr_pkg::OFS_CONTROL, 8'h10);
		bus(1'b0, tmr_pkg::OFS_COUNT, 32'h0, 4'hf);
		hv = rd[7:0];
		m0 = m_cnt;
		repeat (40) @(posedge clk);
		rchk(tmr_pkg::OFS_COUNT, hv, "count held");
		`CHK("no match when off", m0, m_cnt)
		wr(tmr_pkg::OFS_CONTROL, 8'h11);
		rchk(tmr_pkg::OFS_CONTROL, 8'h10, "clear self");
		rchk(tmr_pkg::OFS_COUNT, 8'h00, "cleared");
		// Capture mode on the external clock; the match write lands in capture mode.
		wr(tmr_pkg::OFS_CONTROL, 8'hbe);
		wr(tmr_pkg::OFS_MATCH, 8'h09);
		m0 = m_cnt;
		t0 = t_cnt;
		ext(4);
		@(posedge clk) trg <= 1'b1;
		@(posedge clk) trg <= 1'b0;
		rchk(tmr_pkg::OFS_MATCH, 8'h04, "captured");
		ext(6);
		rchk(tmr_pkg::OFS_COUNT, 8'h00, "capture clear");
		`CHK("capture match", m0 + 1, m_cnt)
		`CHK("no capture toggle", t0, t_cnt)
		wr(tmr_pkg::OFS_CONTROL, 8'h0e);
		rchk(tmr_pkg::OFS_MATCH, 8'h09, "match readback");
		wr(tmr_pkg::OFS_CONTROL, 8'ha0);
		wait_ev(1'b0, p);
		wait_ev(1'b0, p);
		`CHK("capture period", 20, p)
		conclude();
	end
endmodule // tb_top
`default_nettype wire

// >>> tmr_pkg.sv
`default_nettype none
// ---------------------------------------------------------------------------
// Shared constants of the 8-bit match, PWM and capture timer.
// ---------------------------------------------------------------------------
package tmr_pkg;
	// Register byte offsets on the bus.
	localparam logic [7:0] OFS_CONTROL = 8'hb2;
	localparam logic [7:0] OFS_COUNT   = 8'hb3;
	localparam logic [7:0] OFS_MATCH   = 8'hb4;
	// Control register field positions.
	localparam int BIT_ON    = 7;
	localparam int BIT_MODE1 = 5;
	localparam int BIT_MODE0 = 4;
	localparam int BIT_CK2   = 3;
	localparam int BIT_CK0   = 1;
	localparam int BIT_CLR   = 0;
	// Reset values.
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_COUNT   = 8'h00;
	localparam logic [7:0] RST_MATCH   = 8'hff;
	localparam logic [7:0] RST_CAPTURE = 8'h00;
	// Prescaler width, enough for the largest ratio of 2048.
	localparam int PRE_W = 11;
	// Clock select code that picks the external count clock.
	localparam logic [2:0] CK_EXTERNAL = 3'h7;
	// Operating modes, one-hot.
	typedef enum logic [2:0] {
		TMR_COUNTER = 3'b001,
		TMR_PWM     = 3'b010,
		TMR_CAPTURE = 3'b100
	} tmr_mode_t;
endpackage
`default_nettype wire

// >>> tmr_timer8.sv
`timescale 1ns/100ps
`default_nettype none
module tmr_timer8 #(
	parameter int CNT_W = 8
) (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             reset_n,
	// Classic Wishbone slave.
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [7:0]       wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	output logic                  wb_err_o,
	// Pins.
	input  wire logic             ext_count_clock,
	input  wire logic             capture_trigger_input,
	output logic                  match_toggle_out,
	output logic                  pwm_wave_out,
	// Events toward the shared interrupt flag register.
	output logic                  match_irq_pulse,
	output logic                  overflow_irq_pulse
);
	// -----------------------------------------------------------------------
	// Register state.
	// -----------------------------------------------------------------------
	logic [7:0]           control_r;
	logic [CNT_W-1:0]     count_r;
	logic [CNT_W-1:0]     match_r;
	logic [CNT_W-1:0]     capture_r;
	logic [tmr_pkg::PRE_W-1:0] pre_r;
	logic                 ext_prev_r;
	logic                 tick_nxt;
	logic                 is_match;
	tmr_pkg::tmr_mode_t   mode;

	logic       timer_on;
	logic [2:0] clock_source_select;
	assign timer_on            = control_r[tmr_pkg::BIT_ON];
	assign clock_source_select = control_r[tmr_pkg::BIT_CK2:tmr_pkg::BIT_CK0];

	// -----------------------------------------------------------------------
	// Bus slave.
	// -----------------------------------------------------------------------
	logic req;
	logic hit;
	logic wr;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign hit = (wb_adr_i == tmr_pkg::OFS_CONTROL) || (wb_adr_i == tmr_pkg::OFS_COUNT)
		|| (wb_adr_i == tmr_pkg::OFS_MATCH);
	assign wr  = req && hit && wb_we_i && wb_sel_i[0];

	// Answer one cycle after the request; unmapped addresses get err.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
		end else begin
			wb_ack_o <= req && hit;
			wb_err_o <= req && !hit;
		end
	end

	// Read data is registered; in capture mode the shared offset shows the capture.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req && hit && !wb_we_i) begin
			case (wb_adr_i)
				tmr_pkg::OFS_CONTROL: wb_dat_o <= {24'h00_0000, control_r & 8'hbf};
				tmr_pkg::OFS_COUNT:   wb_dat_o <= {24'h00_0000, 8'(count_r)};
				tmr_pkg::OFS_MATCH:   wb_dat_o <= {24'h00_0000,
					(mode == tmr_pkg::TMR_CAPTURE) ? 8'(capture_r) : 8'(match_r)};
				default:              wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// Control register; the clear bit drops itself at the same edge that it zeroes the count.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			control_r <= tmr_pkg::RST_CONTROL;
		end else if (wr && wb_adr_i == tmr_pkg::OFS_CONTROL) begin
			control_r <= wb_dat_i[7:0] & 8'hbf;
		end else begin
			control_r[tmr_pkg::BIT_CLR] <= 1'b0;
		end
	end

	// Match value; writes always land here, even in capture mode.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			match_r <= CNT_W'(tmr_pkg::RST_MATCH);
		end else if (wr && wb_adr_i == tmr_pkg::OFS_MATCH) begin
			match_r <= CNT_W'(wb_dat_i[7:0]);
		end
	end

	// -----------------------------------------------------------------------
	// Mode decode.
	// -----------------------------------------------------------------------
	always_comb begin
		case (control_r[tmr_pkg::BIT_MODE1:tmr_pkg::BIT_MODE0])
			2'h0:    mode = tmr_pkg::TMR_COUNTER;
			2'h1:    mode = tmr_pkg::TMR_PWM;
			default: mode = tmr_pkg::TMR_CAPTURE;
		endcase
	end

	// -----------------------------------------------------------------------
	// Timer clock: prescaler taps or external rising edge.
	// -----------------------------------------------------------------------
	// The prescaler runs free so a ratio change takes effect at once.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_r      <= '0;
			ext_prev_r <= 1'b0;
		end else begin
			pre_r      <= pre_r + 1'b1;
			ext_prev_r <= ext_count_clock;
		end
	end

	// A tick is the cycle where the low bits of the prescaler all wrap.
	always_comb begin
		case (clock_source_select)
			3'h0:    tick_nxt = pre_r[0] == 1'b1;
			3'h1:    tick_nxt = pre_r[1:0] == 2'h3;
			3'h2:    tick_nxt = pre_r[2:0] == 3'h7;
			3'h3:    tick_nxt = pre_r[4:0] == 5'h1f;
			3'h4:    tick_nxt = pre_r[6:0] == 7'h7f;
			3'h5:    tick_nxt = pre_r[8:0] == 9'h1ff;
			3'h6:    tick_nxt = pre_r[10:0] == 11'h7ff;
			default: tick_nxt = ext_count_clock && !ext_prev_r;
		endcase
	end

	logic tick;
	assign tick     = timer_on && tick_nxt;
	// Zero match value is left undefined; it simply compares like any other.
	assign is_match = (count_r == match_r);

	// -----------------------------------------------------------------------
	// Counter.
	// -----------------------------------------------------------------------
	// A match is acted on at the tick that leaves the matching count.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_r <= CNT_W'(tmr_pkg::RST_COUNT);
		end else if (control_r[tmr_pkg::BIT_CLR]) begin
			count_r <= '0;
		end else if (tick) begin
			if (is_match && mode != tmr_pkg::TMR_PWM)
				count_r <= '0;
			else
				count_r <= count_r + 1'b1;
		end
	end

	// -----------------------------------------------------------------------
	// Events, one clock wide, for the external flag register.
	// -----------------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			match_irq_pulse    <= 1'b0;
			overflow_irq_pulse <= 1'b0;
		end else begin
			match_irq_pulse    <= tick && is_match;
			overflow_irq_pulse <= tick && mode == tmr_pkg::TMR_PWM
				&& count_r == {CNT_W{1'b1}};
		end
	end

	// -----------------------------------------------------------------------
	// Outputs: toggle and PWM.
	// -----------------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			match_toggle_out <= 1'b0;
		end else if (tick && is_match && mode == tmr_pkg::TMR_COUNTER) begin
			match_toggle_out <= !match_toggle_out;
		end
	end

	// High from wrap until the match count, low after; the pin mux is outside.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pwm_wave_out <= 1'b0;
		end else if (mode != tmr_pkg::TMR_PWM || !timer_on) begin
			pwm_wave_out <= 1'b0;
		end else if (tick && count_r == {CNT_W{1'b1}}) begin
			pwm_wave_out <= 1'b1;
		end else if (tick && is_match) begin
			pwm_wave_out <= 1'b0;
		end
	end

	// -----------------------------------------------------------------------
	// Capture: trigger arrives already edge-qualified by interrupt logic.
	// -----------------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			capture_r <= CNT_W'(tmr_pkg::RST_CAPTURE);
		end else if (timer_on && mode == tmr_pkg::TMR_CAPTURE && capture_trigger_input) begin
			capture_r <= count_r;
		end
	end

	// -----------------------------------------------------------------------
	// Checks.
	// -----------------------------------------------------------------------
	cnt_match_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
		(tick && is_match && mode != tmr_pkg::TMR_PWM && !control_r[0]) |=> count_r == '0)
		else $error("Count not cleared on match.");
	cnt_advance_a: assert property (@(posedge clk) disable iff (!reset_n)
		(tick && !is_match && !control_r[0]) |=> count_r == $past(count_r) + 1'b1)
		else $error("Count did not advance.");
	cnt_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		(!timer_on && !control_r[0]) |=> $stable(count_r))
		else $error("Disabled count moved.");
	clr_self_a: assert property (@(posedge clk) disable iff (!reset_n)
		(control_r[0] && !wr) |=> !control_r[0] && count_r == '0)
		else $error("Clear bit stuck.");
	match_event_a: assert property (@(posedge clk) disable iff (!reset_n)
		(tick && is_match) |=> match_irq_pulse)
		else $error("Match event missing.");
	pwm_wrap_a: assert property (@(posedge clk) disable iff (!reset_n)
		(tick && mode == tmr_pkg::TMR_PWM && count_r == {CNT_W{1'b1}} && !control_r[0])
		|=> overflow_irq_pulse && count_r == '0)
		else $error("PWM wrap wrong.");
	toggle_flip_a: assert property (@(posedge clk) disable iff (!reset_n)
		(tick && is_match && mode == tmr_pkg::TMR_COUNTER)
		|=> match_toggle_out != $past(match_toggle_out))
		else $error("Toggle missed.");
	cap_load_a: assert property (@(posedge clk) disable iff (!reset_n)
		(timer_on && mode == tmr_pkg::TMR_CAPTURE && capture_trigger_input)
		|=> capture_r == $past(count_r))
		else $error("Capture not loaded.");
	bus_ack_a: assert property (@(posedge clk) disable iff (!reset_n)
		(req && hit) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("Ack timing wrong.");

	// -----------------------------------------------------------------------
	// Bus checks.
	// -----------------------------------------------------------------------
	// A held request must not be answered twice, so ack lasts one cycle.
	ack_single_a: assert property (@(posedge clk) disable iff (!reset_n)
		wb_ack_o |=> !wb_ack_o)
		else $error("Ack lasted more than one cycle.");
	// The error answer follows the same one-cycle rule as ack.
	err_single_a: assert property (@(posedge clk) disable iff (!reset_n)
		wb_err_o |=> !wb_err_o)
		else $error("Err lasted more than one cycle.");
	// A master must never see both answers for one request.
	ack_err_excl_a: assert property (@(posedge clk) disable iff (!reset_n)
		!(wb_ack_o && wb_err_o))
		else $error("Ack and err together.");
	// Unmapped addresses are refused with err one cycle after the request.
	bus_err_a: assert property (@(posedge clk) disable iff (!reset_n)
		(req && !hit) |=> wb_err_o)
		else $error("Unmapped access not refused.");
	// A control write lands whole, with the unused bit forced to zero.
	ctl_write_a: assert property (@(posedge clk) disable iff (!reset_n)
		(wr && wb_adr_i == tmr_pkg::OFS_CONTROL) |=> control_r == ($past(wb_dat_i[7:0]) & 8'hbf))
		else $error("Control write lost.");
	// The shared offset always writes the match value, in every mode.
	match_write_a: assert property (@(posedge clk) disable iff (!reset_n)
		(wr && wb_adr_i == tmr_pkg::OFS_MATCH) |=> match_r == CNT_W'($past(wb_dat_i[7:0])))
		else $error("Match write lost.");
	// In capture mode a read of the shared offset returns the capture.
	cap_read_a: assert property (@(posedge clk) disable iff (!reset_n)
		(req && hit && !wb_we_i && wb_adr_i == tmr_pkg::OFS_MATCH && mode == tmr_pkg::TMR_CAPTURE)
		|=> wb_dat_o == {24'h00_0000, 8'($past(capture_r))})
		else $error("Capture read wrong.");
	// Outside capture mode the shared offset reads back the match value.
	match_read_a: assert property (@(posedge clk) disable iff (!reset_n)
		(req && hit && !wb_we_i && wb_adr_i == tmr_pkg::OFS_MATCH && mode != tmr_pkg::TMR_CAPTURE)
		|=> wb_dat_o == {24'h00_0000, 8'($past(match_r))})
		else $error("Match read wrong.");
	// A count read shows the count of the cycle in which it was taken.
	cnt_read_a: assert property (@(posedge clk) disable iff (!reset_n)
		(req && hit && !wb_we_i && wb_adr_i == tmr_pkg::OFS_COUNT)
		|=> wb_dat_o == {24'h00_0000, 8'($past(count_r))})
		else $error("Count read wrong.");

	// -----------------------------------------------------------------------
	// Timer clock and counter checks.
	// -----------------------------------------------------------------------
	// The high mode bit alone picks capture, whatever the low bit says.
	mode_decode_a: assert property (@(posedge clk) disable iff (!reset_n)
		mode == (control_r[tmr_pkg::BIT_MODE1] ? tmr_pkg::TMR_CAPTURE
		: (control_r[tmr_pkg::BIT_MODE0] ? tmr_pkg::TMR_PWM : tmr_pkg::TMR_COUNTER)))
		else $error("Mode decode wrong.");
	// Every prescaled ratio is even, so its tick falls on an odd prescaler phase.
	pre_phase_a: assert property (@(posedge clk) disable iff (!reset_n)
		(tick && clock_source_select != tmr_pkg::CK_EXTERNAL) |-> pre_r[0])
		else $error("Prescaled tick off phase.");
	// At the fastest ratio two ticks never come back to back.
	div2_rate_a: assert property (@(posedge clk) disable iff (!reset_n)
		(tick && clock_source_select == 3'h0)
		|=> !tick || clock_source_select == tmr_pkg::CK_EXTERNAL)
		else $error("Divide by two rate wrong.");
	// The external clock ticks exactly on a rising pin edge.
	ext_edge_a: assert property (@(posedge clk) disable iff (!reset_n)
		(timer_on && clock_source_select == tmr_pkg::CK_EXTERNAL) |-> tick == $rose(ext_count_clock))
		else $error("External edge tick wrong.");
	// The clear bit beats any tick, in every mode.
	clr_wins_a: assert property (@(posedge clk) disable iff (!reset_n)
		control_r[tmr_pkg::BIT_CLR] |=> count_r == '0)
		else $error("Clear bit did not clear.");
	// In PWM mode a match must not clear; the count runs on.
	pwm_run_a: assert property (@(posedge clk) disable iff (!reset_n)
		(tick && mode == tmr_pkg::TMR_PWM && is_match && !control_r[tmr_pkg::BIT_CLR])
		|=> count_r == $past(count_r) + 1'b1)
		else $error("PWM match cleared the count.");
	// A stopped timer must stay silent toward the flag register.
	off_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
		!timer_on |=> !match_irq_pulse && !overflow_irq_pulse)
		else $error("Event from a stopped timer.");
	// A match event only ever follows a tick at the matching count.
	match_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
		match_irq_pulse |-> $past(tick && is_match))
		else $error("Spurious match event.");

	// -----------------------------------------------------------------------
	// Output and capture checks.
	// -----------------------------------------------------------------------
	// Overflow is gated on PWM mode, so counter and capture modes raise none.
	ovf_pwm_only_a: assert property (@(posedge clk) disable iff (!reset_n)
		(mode != tmr_pkg::TMR_PWM) |=> !overflow_irq_pulse)
		else $error("Overflow outside PWM mode.");
	// The wave idles low so the shared pin is quiet outside PWM mode.
	pwm_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
		(mode != tmr_pkg::TMR_PWM || !timer_on) |=> !pwm_wave_out)
		else $error("PWM wave outside PWM mode.");
	// The wave goes high at the wrap tick.
	pwm_rise_a: assert property (@(posedge clk) disable iff (!reset_n)
		(tick && mode == tmr_pkg::TMR_PWM && count_r == {CNT_W{1'b1}}) |=> pwm_wave_out)
		else $error("PWM wave did not rise at wrap.");
	// The wave goes low at the tick that leaves the match count, unless that tick is the wrap tick, where the rise wins.
	pwm_fall_a: assert property (@(posedge clk) disable iff (!reset_n)
		(tick && mode == tmr_pkg::TMR_PWM && is_match && count_r != {CNT_W{1'b1}})
		|=> !pwm_wave_out)
		else $error("PWM wave did not fall at match.");
	// Outside capture mode a stray trigger must not disturb the capture.
	cap_mode_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		(mode != tmr_pkg::TMR_CAPTURE) |=> $stable(capture_r))
		else $error("Capture moved outside capture mode.");
	// A stopped timer takes no capture.
	cap_off_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		!timer_on |=> $stable(capture_r))
		else $error("Capture moved while stopped.");
	// The toggle pin freezes in capture mode, even on a match.
	cap_no_toggle_a: assert property (@(posedge clk) disable iff (!reset_n)
		(mode == tmr_pkg::TMR_CAPTURE) |=> $stable(match_toggle_out))
		else $error("Toggle moved in capture mode.");
endmodule // tmr_timer8
`default_nettype wire
